/* File: pde_pin_control.sv */
// Pin control for an 8-bit shared port and a 4-bit port, with APB registers.
// Assumes slave handshake and PWM logic run on clk; pins are asynchronous.
`timescale 1ns/1ps
`include "pde_consts.svh"

module pde_pin_control
    import pde_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // First port pins
    input  wire logic [7:0]  firstPortIn,
    output logic      [7:0]  firstPortOut,
    output logic      [7:0]  firstPortOe_n,
    // Second port pins
    input  wire logic [3:0]  secondPortIn,
    output logic      [2:0]  secondPortOut,
    output logic      [2:0]  secondPortOe_n,
    // Straps
    input  wire logic        largePackage,
    input  wire logic        masterClearPinEnable,
    // PWM unit, channels B, C, D in bits 0..2
    input  wire logic [2:0]  pwmData,
    input  wire logic [2:0]  pwmSelect,
    input  wire logic        pwmMultiOutput,
    input  wire logic        pwmShutdown,
    input  wire logic        pwmShutdownTristate,
    // Slave handshake logic
    input  wire logic        slaveWriteStrobe,
    input  wire logic        slaveReadStrobe,
    input  wire logic        slaveReadDrive,
    // Status outputs
    output logic             masterClearReq,
    output logic             slavePortActive,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]    firstSync;
    logic [3:0]    secondSync;
    logic [1:0]    strapSync;
    logic [1:0]    strapCnt_q;
    logic          large_q;
    logic          mclrEn_q;
    logic [7:0]    firstLatch_q;
    logic [7:0]    firstDir_q;
    logic [7:0]    inBuf_q;
    logic [2:0]    secondLatch_q;
    logic [2:0]    secondDir_q;
    logic [2:0]    analogSel_q;
    logic [4:0]    slew_q;
    logic          slaveSel_q;
    logic          inFull_q;
    logic          outFull_q;
    logic          overflow_q;
    logic [2:0]    irqStatus_q;
    logic [2:0]    irqMask_q;
    logic          slaveActive;
    logic          setup;
    logic          access;
    logic          wrEn;
    logic          rdInBuf;
    logic          cpuLatchWr;
    logic          mapped;
    logic [31:0]   readData;
    logic [7:0]    firstOut_d;
    logic [7:0]    firstOe_d;
    logic [2:0]    secondOut_d;
    logic [2:0]    secondOe_d;
    logic [2:0]    irqSet;
    pde_pin_mode_t firstMode [8];

    pde_sync #(.W(8)) uFirstSync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      (firstPortIn),
        .q      (firstSync)
    );
    pde_sync #(.W(4)) uSecondSync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      (secondPortIn),
        .q      (secondSync)
    );
    pde_sync #(.W(2)) uStrapSync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      ({largePackage, masterClearPinEnable}),
        .q      (strapSync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Straps are caught once, after the synchroniser has settled
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strapCnt_q <= 2'h0;
            large_q    <= `PDE_RST_LARGE;
            mclrEn_q   <= `PDE_RST_MCLR_EN;
        end
        else if (strapCnt_q != `PDE_STRAP_DONE)
        begin
            strapCnt_q <= strapCnt_q + 2'h1;
            if (strapCnt_q == `PDE_STRAP_WAIT)
            begin
                large_q  <= strapSync[1];
                mclrEn_q <= strapSync[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB decode: one wait-free access phase after each setup
    assign setup      = psel & ~penable;
    assign access     = psel & penable & pready;
    assign wrEn       = access & pwrite;
    assign slaveActive = slaveSel_q & ~pwmMultiOutput & large_q;
    assign rdInBuf    = access & ~pwrite & slaveActive & (paddr == `PDE_OFF_FIRST_PINS);
    assign cpuLatchWr = wrEn & ((paddr == `PDE_OFF_FIRST_PINS) |
                                (paddr == `PDE_OFF_FIRST_LATCH));

    always_comb
    begin
        readData = 32'h0;
        mapped   = 1'b1;
        case (paddr)
            `PDE_OFF_FIRST_PINS:
                if (large_q)
                    readData[7:0] = slaveActive ? inBuf_q : firstSync;
            `PDE_OFF_FIRST_LATCH:
                if (large_q)
                    readData[7:0] = firstLatch_q;
            `PDE_OFF_FIRST_DIR:
                if (large_q)
                    readData[7:0] = firstDir_q;
            `PDE_OFF_SECOND_PINS:
            begin
                if (large_q)
                    readData[2:0] = secondSync[2:0] & ~analogSel_q;
                readData[`PDE_BIT_INPUT_ONLY] = secondSync[3] & ~mclrEn_q;
            end
            `PDE_OFF_SECOND_LATCH:
                if (large_q)
                    readData[2:0] = secondLatch_q;
            `PDE_OFF_SECOND_DIR:
                if (large_q)
                begin
                    readData[`PDE_BIT_IN_FULL]   = inFull_q;
                    readData[`PDE_BIT_OUT_FULL]  = outFull_q;
                    readData[`PDE_BIT_OVERFLOW]  = overflow_q;
                    readData[`PDE_BIT_SLAVE_SEL] = slaveSel_q;
                    readData[2:0]                = secondDir_q;
                end
            `PDE_OFF_ANALOG_SEL:
                if (large_q)
                    readData[2:0] = analogSel_q;
            `PDE_OFF_SLEW:
                readData[4:0] = large_q ? slew_q : {2'h0, slew_q[2:0]};
            `PDE_OFF_IRQ_STATUS:
                readData[2:0] = irqStatus_q;
            `PDE_OFF_IRQ_MASK:
                readData[2:0] = irqMask_q;
            default:
                mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            if (setup & ~pwrite)
                prdata <= readData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-written registers; only the slew and interrupt mask writes land on the small package
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            firstLatch_q  <= 8'h00;
            firstDir_q    <= `PDE_RST_FIRST_DIR;
            secondLatch_q <= 3'h0;
            secondDir_q   <= `PDE_RST_SECOND_DIR;
            analogSel_q   <= `PDE_RST_ANALOG_SEL;
            slew_q        <= `PDE_RST_SLEW;
            slaveSel_q    <= 1'b0;
            irqMask_q     <= 3'h0;
        end
        else if (wrEn)
        begin
            if (large_q & cpuLatchWr)
                firstLatch_q <= pwdata[7:0];
            if (large_q & (paddr == `PDE_OFF_FIRST_DIR))
                firstDir_q <= pwdata[7:0];
            if (large_q & ((paddr == `PDE_OFF_SECOND_PINS) |
                           (paddr == `PDE_OFF_SECOND_LATCH)))
                secondLatch_q <= pwdata[2:0];
            if (large_q & (paddr == `PDE_OFF_SECOND_DIR))
            begin
                secondDir_q <= pwdata[2:0];
                slaveSel_q  <= pwdata[`PDE_BIT_SLAVE_SEL];
            end
            if (large_q & (paddr == `PDE_OFF_ANALOG_SEL))
                analogSel_q <= pwdata[2:0];
            if (paddr == `PDE_OFF_SLEW)
                slew_q <= large_q ? pwdata[4:0] : {2'h0, pwdata[2:0]};
            if (paddr == `PDE_OFF_IRQ_MASK)
                irqMask_q <= pwdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slave buffer flags; a hardware set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            inBuf_q    <= 8'h00;
            inFull_q   <= 1'b0;
            outFull_q  <= 1'b0;
            overflow_q <= 1'b0;
        end
        else
        begin
            if (slaveActive & slaveWriteStrobe)
                inBuf_q <= firstSync;
            if (slaveActive & slaveWriteStrobe)
                inFull_q <= 1'b1;
            else if (rdInBuf)
                inFull_q <= 1'b0;
            if (slaveActive & cpuLatchWr)
                outFull_q <= 1'b1;
            else if (slaveReadStrobe)
                outFull_q <= 1'b0;
            if (slaveActive & slaveWriteStrobe & inFull_q & ~rdInBuf)
                overflow_q <= 1'b1;
            else if (large_q & wrEn & (paddr == `PDE_OFF_SECOND_DIR))
                overflow_q <= pwdata[`PDE_BIT_OVERFLOW];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky, write one to clear, set wins
    assign irqSet[`PDE_IRQ_RECEIVED] = slaveActive & slaveWriteStrobe;
    assign irqSet[`PDE_IRQ_SENT]     = slaveActive & slaveReadStrobe & outFull_q;
    assign irqSet[`PDE_IRQ_OVERFLOW] = slaveActive & slaveWriteStrobe & inFull_q & ~rdInBuf;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irqStatus_q <= 3'h0;
            irq         <= 1'b0;
        end
        else
        begin
            if (wrEn & (paddr == `PDE_OFF_IRQ_STATUS))
                irqStatus_q <= (irqStatus_q & ~pwdata[2:0]) | irqSet;
            else
                irqStatus_q <= irqStatus_q | irqSet;
            irq <= |(irqStatus_q & irqMask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin muxing, priority PWM > slave > port
    always_comb
    begin
        firstOut_d = 8'h00;
        firstOe_d  = 8'hff;
        for (int i = 0; i < 8; i++)
        begin
            if (!large_q)
                firstMode[i] = PDE_MODE_HIZ;
            else if (i >= `PDE_PWM_FIRST && pwmSelect[i-`PDE_PWM_FIRST] && !firstDir_q[i])
                firstMode[i] = (pwmShutdown & pwmShutdownTristate) ?
                               PDE_MODE_HIZ : PDE_MODE_PWM;
            else if (slaveActive)
                firstMode[i] = PDE_MODE_SLAVE;
            else
                firstMode[i] = PDE_MODE_PORT;
            case (firstMode[i])
                PDE_MODE_PORT:
                begin
                    firstOut_d[i] = firstLatch_q[i];
                    firstOe_d[i]  = firstDir_q[i];
                end
                PDE_MODE_SLAVE:
                begin
                    firstOut_d[i] = firstLatch_q[i];
                    firstOe_d[i]  = ~slaveReadDrive;
                end
                PDE_MODE_PWM:
                begin
                    firstOut_d[i] = pwmData[i-`PDE_PWM_FIRST];
                    firstOe_d[i]  = 1'b0;
                end
                default:
                begin
                    firstOut_d[i] = 1'b0;
                    firstOe_d[i]  = 1'b1;
                end
            endcase
        end
    end

    // Slave handshake pins are inputs while the slave port runs and on the small package;
    // otherwise the direction bits rule even over analog-selected pins.
    always_comb
    begin
        secondOut_d = 3'h0;
        secondOe_d  = 3'h7;
        if (large_q & ~slaveActive)
        begin
            secondOut_d = secondLatch_q;
            secondOe_d  = secondDir_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            firstPortOut    <= 8'h00;
            firstPortOe_n   <= 8'hff;
            secondPortOut   <= 3'h0;
            secondPortOe_n  <= 3'h7;
            slavePortActive <= 1'b0;
            masterClearReq  <= 1'b0;
        end
        else
        begin
            firstPortOut    <= firstOut_d;
            firstPortOe_n   <= firstOe_d;
            secondPortOut   <= secondOut_d;
            secondPortOe_n  <= secondOe_d;
            slavePortActive <= slaveActive;
            masterClearReq  <= mclrEn_q & ~secondSync[3];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_apbReady;
        setup |=> pready ##1 !pready || (psel && !penable);
    endproperty
    a_apbReady: assert property (p_apbReady) else $error("pready not one cycle after setup");

    property p_inFull;
        slaveActive && slaveWriteStrobe |=> inFull_q;
    endproperty
    a_inFull: assert property (p_inFull) else $error("input full not set");

    property p_outFull;
        slaveActive && cpuLatchWr |=> outFull_q;
    endproperty
    a_outFull: assert property (p_outFull) else $error("output full not set");

    property p_overflow;
        slaveActive && slaveWriteStrobe && inFull_q && !rdInBuf |=> overflow_q [*2] or
        (overflow_q ##1 1'b1);
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");

    property p_pwmDrive;
        large_q && pwmSelect[0] && !firstDir_q[5] && !pwmShutdown
        |=> !firstPortOe_n[5] && firstPortOut[5] == $past(pwmData[0]);
    endproperty
    a_pwmDrive: assert property (p_pwmDrive) else $error("PWM B not on pin 5");

    property p_pwmFloat;
        large_q && pwmSelect[2] && !firstDir_q[7] && pwmShutdown && pwmShutdownTristate
        |=> firstPortOe_n[7];
    endproperty
    a_pwmFloat: assert property (p_pwmFloat) else $error("PWM D not floated");

    property p_slaveDrive;
        slaveActive && slaveReadDrive && !pwmSelect[0]
        |=> !firstPortOe_n[`PDE_SLAVE_BIT_SHOWN] &&
            firstPortOut[`PDE_SLAVE_BIT_SHOWN] == $past(firstLatch_q[`PDE_SLAVE_BIT_SHOWN]);
    endproperty
    a_slaveDrive: assert property (p_slaveDrive) else $error("slave read not driven");

    property p_dirInput;
        large_q && !slaveActive && firstDir_q[0] |=> firstPortOe_n[0];
    endproperty
    a_dirInput: assert property (p_dirInput) else $error("input pin driven");

    property p_analogZero;
        setup && !pwrite && paddr == `PDE_OFF_SECOND_PINS && analogSel_q[1] |=> !prdata[1];
    endproperty
    a_analogZero: assert property (p_analogZero) else $error("analog pin read nonzero");

    property p_multiPwm;
        pwmMultiOutput |=> !slavePortActive;
    endproperty
    a_multiPwm: assert property (p_multiPwm) else $error("slave port left on");

    property p_mclrRead;
        setup && !pwrite && paddr == `PDE_OFF_SECOND_PINS && mclrEn_q
        |=> !prdata[`PDE_BIT_INPUT_ONLY];
    endproperty
    a_mclrRead: assert property (p_mclrRead) else $error("pin 3 read as data");

endmodule // pde_pin_control

/* File: pde_consts.svh */
// Offsets, reset values and field positions of the port pin control block.
// Assumes a 32-bit APB slave decoding an 8-bit byte address.
`ifndef PDE_CONSTS_SVH
`define PDE_CONSTS_SVH

// Register byte addresses
`define PDE_OFF_FIRST_PINS   8'h00
`define PDE_OFF_FIRST_LATCH  8'h04
`define PDE_OFF_FIRST_DIR    8'h08
`define PDE_OFF_SECOND_PINS  8'h0c
`define PDE_OFF_SECOND_LATCH 8'h10
`define PDE_OFF_SECOND_DIR   8'h14
`define PDE_OFF_ANALOG_SEL   8'h18
`define PDE_OFF_SLEW         8'h1c
`define PDE_OFF_IRQ_STATUS   8'h20
`define PDE_OFF_IRQ_MASK     8'h24

// Reset values
`define PDE_RST_FIRST_DIR    8'hff
`define PDE_RST_SECOND_DIR   3'h7
`define PDE_RST_ANALOG_SEL   3'h7
`define PDE_RST_SLEW         5'h00
`define PDE_RST_LARGE        1'b0
`define PDE_RST_MCLR_EN      1'b1

// Second port direction register fields; the input-only bit sits in the second port pins register
`define PDE_BIT_IN_FULL      7
`define PDE_BIT_OUT_FULL     6
`define PDE_BIT_OVERFLOW     5
`define PDE_BIT_SLAVE_SEL    4
`define PDE_BIT_INPUT_ONLY   3

// Slew control: bits at and above this exist on the large package only
`define PDE_SLEW_LARGE_LSB   3

// Interrupt status bits
`define PDE_IRQ_RECEIVED     0
`define PDE_IRQ_SENT         1
`define PDE_IRQ_OVERFLOW     2

// First pin shared with the PWM channels
`define PDE_PWM_FIRST        5
`define PDE_SLAVE_BIT_SHOWN  4

// Cycles after reset release before the straps are caught
`define PDE_STRAP_WAIT       2'd2
`define PDE_STRAP_DONE       2'd3

`endif

/* File: pde_pkg.sv */
// Types shared by the port pin control block.
// Assumes the constants header is compiled alongside.
package pde_pkg;
    typedef enum logic [1:0] {
        PDE_MODE_PORT,
        PDE_MODE_SLAVE,
        PDE_MODE_PWM,
        PDE_MODE_HIZ
    } pde_pin_mode_t;
endpackage

/* File: pde_sync.sv */
// Two-flop synchroniser for pin levels.
// Assumes the input changes slowly compared to clk.
`timescale 1ns/1ps
module pde_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // Level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // pde_sync

/* File: pde_pin_model.sv */
// External circuitry on both ports: resolves each pin from the block's drive.
// Assumes the bench sets the level that outside parts put on released pins.
`timescale 1ns/1ps
module pde_pin_model (
    // Block side
    input  wire logic [7:0] firstPortOut,
    input  wire logic [7:0] firstPortOe_n,
    input  wire logic [2:0] secondPortOut,
    input  wire logic [2:0] secondPortOe_n,
    // Outside levels
    input  wire logic [7:0] extFirst,
    input  wire logic [3:0] extSecond,
    // Pin levels seen by the block
    output logic      [7:0] firstPortIn,
    output logic      [3:0] secondPortIn
);
    // A driven pin shows the block's value; a released one the outside level
    always_comb
    begin
        firstPortIn = (firstPortOut & ~firstPortOe_n) | (extFirst & firstPortOe_n);
        secondPortIn[2:0] = (secondPortOut & ~secondPortOe_n) | (extSecond[2:0] & secondPortOe_n);
        secondPortIn[3] = extSecond[3];
    end
endmodule // pde_pin_model

/* File: tb_top.sv */
// Self-checking bench for the port pin control block.
// Assumes straps only change while reset is held; the APB master waits on pready.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
    $display("Error %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top;
    logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr, firstPortIn, firstPortOut, firstPortOe_n, extFirst;
    logic [31:0] pwdata, prdata, rdData;
    logic [3:0]  secondPortIn, extSecond;
    logic [2:0]  secondPortOut, secondPortOe_n, pwmData, pwmSelect;
    logic        pwmMultiOutput, pwmShutdown, pwmShutdownTristate, rdErr;
    logic        slaveWriteStrobe, slaveReadStrobe, slaveReadDrive;
    logic        masterClearReq, slavePortActive, largeStrap, mclrStrap;
    int          n_fail = 0;
    int          checks = 0;

    pde_pin_control uut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .firstPortIn(firstPortIn), .firstPortOut(firstPortOut),
        .firstPortOe_n(firstPortOe_n), .secondPortIn(secondPortIn),
        .secondPortOut(secondPortOut), .secondPortOe_n(secondPortOe_n),
        .largePackage(largeStrap), .masterClearPinEnable(mclrStrap), .pwmData(pwmData),
        .pwmSelect(pwmSelect), .pwmMultiOutput(pwmMultiOutput), .pwmShutdown(pwmShutdown),
        .pwmShutdownTristate(pwmShutdownTristate), .slaveWriteStrobe(slaveWriteStrobe),
        .slaveReadStrobe(slaveReadStrobe), .slaveReadDrive(slaveReadDrive),
        .masterClearReq(masterClearReq), .slavePortActive(slavePortActive), .irq(irq));
    pde_pin_model pins (.firstPortOut(firstPortOut), .firstPortOe_n(firstPortOe_n),
        .secondPortOut(secondPortOut), .secondPortOe_n(secondPortOe_n),
        .extFirst(extFirst), .extSecond(extSecond), .firstPortIn(firstPortIn),
        .secondPortIn(secondPortIn));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic wrap_up();
        if (n_fail == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Values read before the edge's updates land, so pready is the registered one
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic strobe(input bit wr);
        @(posedge clk);
        if (wr)
            slaveWriteStrobe <= 1'b1;
        else
            slaveReadStrobe <= 1'b1;
        @(posedge clk);
        slaveWriteStrobe <= 1'b0;
        slaveReadStrobe <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #20000;
        n_fail++;
        wrap_up();
    end

    initial
    begin
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {pwmData, pwmSelect, pwmMultiOutput, pwmShutdown, pwmShutdownTristate} = '0;
        {slaveWriteStrobe, slaveReadStrobe, slaveReadDrive} = '0;
        {largeStrap, mclrStrap} = 2'b11;
        extFirst = 8'h3c;
        extSecond = 4'hb;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Reset state, then a slew write
        #1 `CHK(firstPortOe_n, 8'hff)
        rd(8'h08); `CHK(rdData, 32'h0000_00ff)
        rd(8'h14); `CHK(rdData, 32'h0000_0007)
        rd(8'h18); `CHK(rdData, 32'h0000_0007)
        apb(1'b1, 8'h1c, 32'hffff_ffff); rd(8'h1c); `CHK(rdData, 32'h0000_001f)
        // Latch versus pins on the first port
        apb(1'b1, 8'h04, 32'hffff_ffa5); rd(8'h04); `CHK(rdData, 32'h0000_00a5)
        apb(1'b1, 8'h08, 32'h0000_00f0); wt(3);
        `CHK(firstPortOe_n, 8'hf0)
        rd(8'h00); `CHK(rdData, 32'h0000_0035)
        // PWM ownership of pins 5 and 6; pin 7 stays a port pin
        @(posedge clk);
        pwmSelect <= 3'b011;
        pwmData <= 3'b010;
        wt(3); `CHK(firstPortOe_n[7:5], 3'b111)
        apb(1'b1, 8'h08, 32'h0000_0000); wt(3);
        `CHK(firstPortOut[7:5], 3'b110)
        @(posedge clk);
        pwmShutdown <= 1'b1;
        pwmShutdownTristate <= 1'b1;
        wt(3); `CHK(firstPortOe_n[7:5], 3'b011)
        @(posedge clk);
        {pwmSelect, pwmShutdown, pwmShutdownTristate} <= '0;
        // Parallel slave mode
        extFirst <= 8'h77;
        apb(1'b1, 8'h14, 32'h0000_0010); wt(3);
        `CHK(slavePortActive, 1'b1)
        `CHK(firstPortOe_n, 8'hff)
        `CHK(secondPortOe_n, 3'b111)
        @(posedge clk);
        slaveReadDrive <= 1'b1;
        wt(3); `CHK({firstPortOe_n, firstPortOut}, 16'h00a5)
        @(posedge clk);
        slaveReadDrive <= 1'b0;
        apb(1'b1, 8'h04, 32'h0000_005a); rd(8'h14); `CHK(rdData, 32'h0000_0050)
        strobe(1'b0); rd(8'h14); `CHK(rdData, 32'h0000_0010)
        strobe(1'b1); wt(4); `CHK(irq, 1'b0)
        rd(8'h14); `CHK(rdData, 32'h0000_0090)
        strobe(1'b1); rd(8'h14); `CHK(rdData, 32'h0000_00b0)
        apb(1'b1, 8'h24, 32'h0000_0007); wt(3); `CHK(irq, 1'b1)
        rd(8'h20); `CHK(rdData, 32'h0000_0007)
        rd(8'h00); `CHK(rdData, 32'h0000_0077)
        rd(8'h14); `CHK(rdData, 32'h0000_0030)
        apb(1'b1, 8'h14, 32'h0000_0010); rd(8'h14); `CHK(rdData, 32'h0000_0010)
        apb(1'b1, 8'h20, 32'h0000_0007); wt(3); `CHK(irq, 1'b0)
        rd(8'h20); `CHK(rdData, 32'h0000_0000)
        @(posedge clk);
        pwmMultiOutput <= 1'b1;
        wt(3); `CHK(slavePortActive, 1'b0)
        @(posedge clk);
        pwmMultiOutput <= 1'b0;
        // Second port: directions, analog reads, master clear
        apb(1'b1, 8'h14, 32'h0000_0003);
        apb(1'b1, 8'h10, 32'h0000_0005);
        apb(1'b1, 8'h18, 32'h0000_0000); wt(3);
        `CHK({secondPortOe_n, secondPortOut[2]}, 4'b0111)
        rd(8'h0c); `CHK(rdData[2:0], 3'b111)
        apb(1'b1, 8'h18, 32'h0000_0003);
        rd(8'h0c); `CHK(rdData[2:0], 3'b100)
        rd(8'h10); `CHK(rdData, 32'h0000_0005)
        `CHK(masterClearReq, 1'b0)
        extSecond <= 4'h3;
        wt(4); `CHK(masterClearReq, 1'b1)
        rd(8'h3c); `CHK({rdErr, rdData}, 33'h1_0000_0000)
        // Small package with master clear off, caught by a second reset
        @(posedge clk);
        arst_n <= 1'b0;
        {largeStrap, mclrStrap} <= 2'b00;
        extSecond <= 4'h8;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(8'h0c); `CHK(rdData, 32'h0000_0008)
        `CHK(masterClearReq, 1'b0)
        apb(1'b1, 8'h04, 32'h0000_00ff); rd(8'h04); `CHK(rdData, 32'h0000_0000)
        apb(1'b1, 8'h1c, 32'h0000_00ff); rd(8'h1c); `CHK(rdData, 32'h0000_0007)
        wrap_up();
    end
endmodule // tb_top
